//--- verification/error_status_logger_tb.sv
/*
  Self-checking bench for the error status logger: random and corner reports plus
  register traffic. Assumes the logger top, its package and a 125 MHz clock.
*/
`timescale 1ns/1ps
module error_status_logger_tb;
  import err_log_pkg::*;
  // Hi-word bits this block owns: 63, 61, 59 and 56:32
  localparam logic [31:0] HM = 32'ha9ff_ffff;
  logic sys_clk = 1'h0;
  logic rstn = 1'h0;
  logic reportValid = 1'h0;
  logic typeA = 1'h0;
  err_report_t report = '0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [63:0] status;
  int nFail = 0;
  int cmpCount = 0;
  err_report_t r, u;

  always #4 sys_clk = ~sys_clk;

  error_status_logger i_error_status_logger (.sys_clk, .rstn, .reportValid, .report, .typeA,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .status);

  task automatic end_of_test();
    if (nFail == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 64) begin
      nFail++;
      end_of_test();
    end
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw = 0;
    bit w = 0;
    bit b = 0;
    int n = 0;
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b) begin
      tick(n);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'h0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'h0;
      end
      if (bvalid) begin
        b = 1;
        bready <= 1'h0;
        chk(bresp, er);
      end
    end
    // Idle edge so a following call never re-raises bready in the same step
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m,
                    input logic [1:0] er);
    bit ar = 0;
    bit v = 0;
    int n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!v) begin
      tick(n);
      if (!ar && arready) begin
        ar = 1;
        arvalid <= 1'h0;
      end
      if (rvalid) begin
        v = 1;
        rready <= 1'h0;
        chk(rdata & m, ex & m);
        chk(rresp, er);
      end
    end
    // Idle edge so a following call never re-raises rready in the same step
    @(posedge sys_clk);
  endtask

  task automatic send(input err_report_t x, input logic ta);
    report <= x;
    typeA <= ta;
    reportValid <= 1'h1;
    @(posedge sys_clk);
    reportValid <= 1'h0;
    @(posedge sys_clk);
  endtask

  // Random report, corrected or not, kept self-consistent
  function automatic err_report_t rnd(input logic unc);
    logic [31:0] v = $urandom;
    err_report_t x;
    x = v[$bits(err_report_t)-1:0];
    x.uncorrected = unc;
    x.hasCorr = !unc;
    x.hasUncorr = unc;
    if (unc) x.synValid = 1'h0;
    return x;
  endfunction

  function automatic logic [31:0] expHi(input err_report_t x, input logic [7:0] t,
                                        input logic [7:0] thr);
    logic [31:0] h = '0;
    h[31] = 1'h1;
    h[29] = x.uncorrected;
    h[27] = x.extraValid;
    h[7:0] = t;
    if (x.extraValid) h[9:8] = x.format;
    if (x.synValid) h[19:12] = x.syndrome;
    h[20] = x.synValid;
    if (x.tracked && !x.uncorrected) h[22:21] = (t >= thr) ? HEALTH_YELLOW : HEALTH_GREEN;
    return h;
  endfunction

  function automatic logic [2:0] expL3(input logic [3:0] c);
    case (c[3])
      1'h1: return c[0] ? 3'h2 : c[1] ? 3'h1 : c[2] ? 3'h3 : 3'h0;
      default: return {1'h1, c[0], c[1]};
    endcase
  endfunction

  initial begin
    void'($urandom(32'h268d));
    repeat (6) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    chk(status, '0);
    chk(irq, 1'h0);
    rd(OFF_THR_CFG, {24'h0, THR_RESET}, '1, RESP_OKAY);
    rd(OFF_IRQ_MASK, '0, '1, RESP_OKAY);
    rd(8'h40, '0, '1, RESP_SLVERR);
    wr(OFF_STATUS_HI, '1, RESP_SLVERR);
    wr(8'h44, '1, RESP_SLVERR);
    chk(status, '0);
    for (int i = 1; i <= 10; i++) begin
      wr(OFF_CLEAR, 32'h0000_0001, RESP_OKAY);
      chk({status[63], status[39:32]}, {1'h0, 8'(i - 1)});
      r = rnd(1'h0);
      send(r, 1'($urandom));
      chk(status[63:32] & HM, expHi(r, 8'(i), THR_RESET));
    end
    rd(OFF_STATUS_HI, expHi(r, 8'h0a, THR_RESET), HM, RESP_OKAY);
    wr(OFF_THR_CFG, 32'h0000_0005, RESP_OKAY);
    rd(OFF_THR_CFG, 32'h0000_0005, '1, RESP_OKAY);
    wr(OFF_CLEAR, 32'h0000_0001, RESP_OKAY);
    r = rnd(1'h0);
    r.tracked = 1'h1;
    send(r, 1'h0);
    chk(status[63:32] & HM, expHi(r, 8'h0b, 8'h05));
    wr(OFF_CLEAR, 32'h0000_0001, RESP_OKAY);
    u = rnd(1'h1);
    u.tracked = 1'h1;
    send(u, 1'h1);
    chk(status[63:32] & HM, expHi(u, 8'h0b, 8'h05));
    send(rnd(1'h0), 1'h0);
    chk(status[63:40] & HM[31:8], expHi(u, 8'h0b, 8'h05) >> 8);
    chk(irq, 1'h0);
    wr(OFF_IRQ_MASK, 32'h0000_0007, RESP_OKAY);
    rd(OFF_IRQ_MASK, 32'h0000_0007, '1, RESP_OKAY);
    chk(irq, 1'h1);
    rd(OFF_IRQ_STATUS, 32'h0000_0003, 32'h0000_0007, RESP_OKAY);
    @(posedge sys_clk);
    chk(irq, 1'h0);
    rd(OFF_IRQ_STATUS, '0, 32'h0000_0007, RESP_OKAY);
    wr(OFF_IRQ_MASK, 32'h0000_0002, RESP_OKAY);
    send(rnd(1'h0), 1'h0);
    chk(irq, 1'h0);
    wr(OFF_CLEAR, 32'h0000_0001, RESP_OKAY);
    for (int i = 0; i < 32; i++) begin
      r = rnd(1'h0);
      {r.multiWay, r.tagHit, r.hasCorr, r.hasUncorr} = i[3:0];
      send(r, i[4]);
      chk(status[18:16], i[4] ? expL3(i[3:0]) : 3'h0);
    end
    repeat (260) send(rnd(1'h0), 1'h0);
    chk(status[39:32], COUNT_MAX);
    rd(OFF_IRQ_STATUS, 32'h0000_0005, 32'h0000_0005, RESP_OKAY);
    rstn <= 1'h0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    chk(status, '0);
    chk(irq, 1'h0);
    rd(OFF_THR_CFG, {24'h0, THR_RESET}, '1, RESP_OKAY);
    end_of_test();
  end
endmodule

//--- verilog/axil_slave.sv
/*
  Minimal AXI4-Lite slave front end: captures one write and one read.
  Assumes the register file answers reads combinationally from rdData.
*/
`timescale 1ns/1ps
module axil_slave (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output err_log_pkg::bus_word_t wrReq,
  output logic wrStrobe,
  output logic [7:0] rdAddr,
  output logic rdStrobe,
  input wire logic [31:0] rdData,
  input wire logic rdHit,
  input wire logic wrHit
);
  import err_log_pkg::*;

  logic haveAw;
  logic haveW;
  logic [7:0] awHold;
  logic [31:0] wHold;

  assign awready = !haveAw && !bvalid;
  assign wready = !haveW && !bvalid;
  assign arready = !rvalid;
  assign wrStrobe = haveAw && haveW && !bvalid;
  assign wrReq = '{addr: awHold, data: wHold};
  assign rdAddr = araddr;
  assign rdStrobe = arvalid && arready;

  // Either channel may arrive first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      haveAw <= 1'b0;
      haveW <= 1'b0;
      awHold <= 8'h00;
      wHold <= 32'h0000_0000;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        haveAw <= 1'b1;
        awHold <= awaddr;
      end
      if (wvalid && wready) begin
        haveW <= 1'b1;
        // Partial strobes still write the whole word; no byte fields here
        wHold <= (wstrb == 4'h0) ? 32'h0000_0000 : wdata;
      end
      if (wrStrobe) begin
        haveAw <= 1'b0;
        haveW <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (rdStrobe) begin
      rvalid <= 1'b1;
      rdata <= rdHit ? rdData : 32'h0000_0000;
      rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  bHolds_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  rHolds_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rvalid dropped");
endmodule

//--- verilog/err_log_pkg.sv
/*
  Shared constants and types for the bank 4 error status logger.
  Assumes a 32-bit AXI4-Lite register bus on a single 125 MHz clock.
*/
package err_log_pkg;

  // Register byte offsets (64-bit status split into two words)
  localparam logic [7:0] OFF_STATUS_LO = 8'h00;
  localparam logic [7:0] OFF_STATUS_HI = 8'h04;
  localparam logic [7:0] OFF_CLEAR = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_THR_CFG = 8'h14;

  // Field positions within the 64-bit status
  localparam int POS_COUNT = 32;
  localparam int POS_FORMAT = 40;
  localparam int POS_SYNDROME = 44;
  localparam int POS_SYN_VALID = 52;
  localparam int POS_HEALTH = 53;
  localparam int POS_L3_CODE = 16;
  localparam int POS_EXTRA_VALID = 59;
  localparam int POS_UNCORRECTED = 61;
  localparam int POS_LOG_VALID = 63;

  // Reset and saturation values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [7:0] THR_RESET = 8'h10;

  // Health encodings
  localparam logic [1:0] HEALTH_NONE = 2'h0;
  localparam logic [1:0] HEALTH_GREEN = 2'h1;
  localparam logic [1:0] HEALTH_YELLOW = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Interrupt status bits
  localparam int IRQ_CORR = 0;
  localparam int IRQ_UNCORR = 1;
  localparam int IRQ_SAT = 2;

  // One error report from the detecting logic
  typedef struct packed {
    logic uncorrected;
    logic tracked;
    logic extraValid;
    logic [1:0] format;
    logic synValid;
    logic [7:0] syndrome;
    logic multiWay;
    logic tagHit;
    logic hasCorr;
    logic hasUncorr;
  } err_report_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } bus_word_t;

  // L3 way-level code: high bit set for single-way reports
  function automatic logic [2:0] l3_code(input logic multi, input logic tag,
                                         input logic corr, input logic unc);
    logic [2:0] c;
    c = 3'h0;
    if (multi) begin
      if (unc) c = 3'h2;
      else if (corr) c = 3'h1;
      else if (tag) c = 3'h3;
      else c = 3'h0;
    end else begin
      if (corr && unc) c = 3'h7;
      else if (unc) c = 3'h6;
      else if (corr) c = 3'h5;
      else c = 3'h4;
    end
    return c;
  endfunction

endpackage

//--- verilog/error_status_logger.sv
/*
  Bank 4 error status logger: builds the 64-bit status word with the
  correctable tally, extra-info format, ECC syndrome, threshold health and
  L3 way code, plus interrupt status and mask, over AXI4-Lite.
  Assumes error reports arrive as one-cycle pulses on sys_clk.
*/
// Contract
// - Bits 39:32 hold correctable event tally
// - Tally starts at zero, saturates at 255
// - Bits 41:40 give extra info format
// - Bits 51:44 carry correctable ECC syndrome
// - Bit 52 set when syndrome delivered
// - Bits 54:53 report threshold health state
// - Health valid only with valid, defined
// - Bits 56:32 share layout for all types
// - Type A code in bits 18:16
// - Codes 000-011 describe multi-way conditions
// - Codes 100-111 describe single-way conditions
// - Log valid set by hardware, software clears
// - Bit 61 marks uncorrected condition
// - Bit 59 set only with extra info
`timescale 1ns/1ps
module error_status_logger (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reportValid,
  input wire err_log_pkg::err_report_t report,
  input wire logic typeA,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  output logic [63:0] status
);
  import err_log_pkg::*;

  bus_word_t wrReq;
  logic wrStrobe;
  logic [7:0] rdAddr;
  logic rdStrobe;
  logic [31:0] rdData;
  logic rdHit;
  logic wrHit;

  logic [7:0] tally;
  logic tallySat;
  logic corrEvt;
  logic logValid;
  logic uncorrected;
  logic extraValid;
  logic [1:0] format;
  logic [7:0] syndrome;
  logic synValid;
  logic [1:0] health;
  logic [2:0] l3Code;
  logic [7:0] threshold;
  logic [2:0] irqStatus;
  logic [2:0] irqMask;
  logic [2:0] irqEvents;
  logic clearReq;
  logic irqRead;
  logic tallySatPrev;
  logic [1:0] next_health;

  assign corrEvt = reportValid && !report.uncorrected;

  axil_slave bus (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrReq(wrReq),
    .wrStrobe(wrStrobe),
    .rdAddr(rdAddr),
    .rdStrobe(rdStrobe),
    .rdData(rdData),
    .rdHit(rdHit),
    .wrHit(wrHit)
  );

  event_tally tallyUnit (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .evt(corrEvt),
    .tally(tally),
    .saturated(tallySat)
  );

  assign clearReq = wrStrobe && (wrReq.addr == OFF_CLEAR) && wrReq.data[0];
  assign irqRead = rdStrobe && (rdAddr == OFF_IRQ_STATUS);

  always_comb begin
    next_health = HEALTH_NONE;
    if (report.tracked) begin
      next_health = (tally >= threshold) ? HEALTH_YELLOW : HEALTH_GREEN;
    end
  end

  // valid set on report, software clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      logValid <= 1'b0;
    end else if (reportValid) begin
      logValid <= 1'b1;
    end else if (clearReq) begin
      logValid <= 1'b0;
    end
  end

  // Uncorrected logs are not overwritten by later corrected ones
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      uncorrected <= 1'b0;
      extraValid <= 1'b0;
      format <= 2'h0;
      syndrome <= 8'h00;
      synValid <= 1'b0;
      health <= HEALTH_NONE;
      l3Code <= 3'h0;
    end else if (reportValid && !(logValid && uncorrected && !report.uncorrected)) begin
      uncorrected <= report.uncorrected;
      extraValid <= report.extraValid;
      format <= report.extraValid ? report.format : 2'h0;
      synValid <= report.synValid && !report.uncorrected;
      syndrome <= (report.synValid && !report.uncorrected) ? report.syndrome : 8'h00;
      health <= report.uncorrected ? HEALTH_NONE : next_health;
      l3Code <= typeA ? l3_code(report.multiWay, report.tagHit, report.hasCorr,
                               report.hasUncorr) : 3'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      threshold <= THR_RESET;
      irqMask <= IRQ_MASK_RESET;
    end else if (wrStrobe) begin
      if (wrReq.addr == OFF_THR_CFG) threshold <= wrReq.data[7:0];
      if (wrReq.addr == OFF_IRQ_MASK) irqMask <= wrReq.data[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tallySatPrev <= 1'b0;
    end else begin
      tallySatPrev <= tallySat;
    end
  end

  assign irqEvents = {tallySat && !tallySatPrev, reportValid && report.uncorrected, corrEvt};

  // Set wins over read-to-clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus <= 3'h0;
    end else begin
      irqStatus <= (irqRead ? 3'h0 : irqStatus) | irqEvents;
    end
  end

  assign irq = |(irqStatus & irqMask);

  // one auxiliary layout for A, B, C
  always_comb begin
    status = 64'h0000_0000_0000_0000;
    status[POS_LOG_VALID] = logValid;
    status[POS_UNCORRECTED] = uncorrected;
    status[POS_EXTRA_VALID] = extraValid;
    status[POS_HEALTH +: 2] = logValid ? health : HEALTH_NONE;
    status[POS_SYN_VALID] = synValid;
    status[POS_SYNDROME +: 8] = syndrome;
    status[POS_FORMAT +: 2] = extraValid ? format : 2'h0;
    status[POS_COUNT +: 8] = tally;
    status[POS_L3_CODE +: 3] = l3Code;
  end

  always_comb begin
    rdHit = 1'b1;
    case (rdAddr)
      OFF_STATUS_LO: rdData = status[31:0];
      OFF_STATUS_HI: rdData = status[63:32];
      OFF_IRQ_STATUS: rdData = {29'h0, irqStatus};
      OFF_IRQ_MASK: rdData = {29'h0, irqMask};
      OFF_THR_CFG: rdData = {24'h00_0000, threshold};
      OFF_CLEAR: rdData = 32'h0000_0000;
      default: begin
        rdData = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  assign wrHit = (wrReq.addr == OFF_CLEAR) || (wrReq.addr == OFF_IRQ_MASK) ||
                 (wrReq.addr == OFF_THR_CFG);

  countTracks_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    corrEvt && tally == 8'h00 |=> status[39:32] == 8'h01) else $error("first count");
  formatGate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !status[POS_EXTRA_VALID] |-> status[41:40] == 2'h0) else $error("format ungated");
  synCapture_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reportValid && !report.uncorrected && report.synValid && !(logValid && uncorrected) |=>
    status[52] && status[51:44] == $past(report.syndrome)) else $error("syndrome");
  synOnlyCorr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    status[52] |-> !status[61]) else $error("syndrome on uncorrected");
  healthNoRes_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    status[54:53] != 2'h3) else $error("reserved health");
  healthGated_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !status[63] || status[61] |-> status[54:53] == 2'h0) else $error("health gate");
  validSet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reportValid |=> status[63]) else $error("valid not set");
  uncSet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reportValid && report.uncorrected |=> status[61]) else $error("uc not set");
  l3Single_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reportValid && typeA && !report.multiWay && !(logValid && uncorrected)
    |=> status[18]) else $error("single-way code");
  l3Multi_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reportValid && typeA && report.multiWay && !(logValid && uncorrected)
    |=> !status[18]) else $error("multi-way code");
  tallyKept_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    clearReq && !corrEvt |=> $stable(tally)) else $error("tally cleared");

  corrCov_c: cover property (@(posedge sys_clk) disable iff (!rstn) corrEvt);
  uncCov_c: cover property (@(posedge sys_clk) disable iff (!rstn)
    reportValid && report.uncorrected);
  satCov_c: cover property (@(posedge sys_clk) disable iff (!rstn) tallySat);
  irqCov_c: cover property (@(posedge sys_clk) disable iff (!rstn) irq ##1 irqRead);
endmodule

//--- verilog/event_tally.sv
/*
  Saturating eight-bit tally of correctable events.
  Assumes evt is a one-cycle pulse on sys_clk; only reset clears it.
*/
`timescale 1ns/1ps
module event_tally (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic evt,
  output logic [7:0] tally,
  output logic saturated
);
  import err_log_pkg::*;

  assign saturated = (tally == COUNT_MAX);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tally <= COUNT_RESET;
    end else if (evt && !saturated) begin
      tally <= tally + 8'h01;
    end
  end

  stopAt255_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    saturated |=> saturated) else $error("tally left saturation");
  stepOne_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    evt && !saturated |=> tally == $past(tally) + 8'h01) else $error("tally step");
endmodule
